// *** hdl/supervisor_pkg.sv ***
`default_nettype none
package supervisor_pkg;

    // Timebase
    localparam int CLK_MHZ         = 250;
    localparam int CNT_W           = 28;

    // Reset release delay and watchdog time-out
    localparam int RESET_DELAY_MS  = 100;
    localparam int RESET_DELAY_CYC = RESET_DELAY_MS * CLK_MHZ * 1000;
    localparam int WDOG_MS         = 800;
    localparam int WDOG_CYC        = WDOG_MS * CLK_MHZ * 1000;

    // Battery health check
    localparam int BAT_PERIOD_MS   = 200;
    localparam int BAT_PERIOD_CYC  = BAT_PERIOD_MS * CLK_MHZ * 1000;
    localparam int BAT_ON_US       = 25;
    localparam int BAT_ON_CYC      = BAT_ON_US * CLK_MHZ;

    // Chip-select drain time after reset asserts
    localparam int CE_TIMEOUT_US   = 15;
    localparam int CE_TIMEOUT_CYC  = CE_TIMEOUT_US * CLK_MHZ;

    // Freshness seal entry window
    localparam int SEAL_MIN_MS     = 5;
    localparam int SEAL_MIN_CYC    = SEAL_MIN_MS * CLK_MHZ * 1000;
    localparam int SEAL_MAX_MS     = 35;
    localparam int SEAL_MAX_CYC    = SEAL_MAX_MS * CLK_MHZ * 1000;

    // Reset values
    localparam logic BAT_GOOD_RST  = 1'b1;
    localparam logic CS_OUT_RST    = 1'b1;

    typedef logic [CNT_W-1:0] cnt_t;

    // Comparator results and pins, all from outside the clock domain
    typedef struct packed {
        logic above_min;
        logic above_reset;
        logic above_bat;
        logic above_low_line;
        logic bat_above_good;
        logic monitor_above_ref;
        logic force_backup;
        logic cs_in;
        logic kick;
        logic pfo_sense;
    } pins_t;

    localparam int PINS_W = $bits(pins_t);

    typedef enum logic [1:0] {
        RST_HOLD  = 2'b00,
        RST_DELAY = 2'b01,
        RST_RUN   = 2'b10
    } rst_state_t;

    typedef enum logic [1:0] {
        CE_ON    = 2'b00,
        CE_DRAIN = 2'b01,
        CE_OFF   = 2'b10
    } ce_state_t;

endpackage
`default_nettype wire

// *** hdl/signal_sync3.sv ***
`default_nettype none
module signal_sync3 #(
    parameter int W = 1
) (
    // Clock and reset
    input  wire logic         i_clk_sys,
    input  wire logic         i_rst,
    // Data
    input  wire logic [W-1:0] i_d,
    output var  logic [W-1:0] o_q
);

    logic [W-1:0] s1_reg;
    logic [W-1:0] s2_reg;
    logic [W-1:0] s3_reg;
    logic [W-1:0] q_next;

    // A bit moves only when the second and third stages agree
    assign q_next = (~(s2_reg ^ s3_reg) & s3_reg) | ((s2_reg ^ s3_reg) & o_q);

    always_ff @(posedge i_clk_sys or posedge i_rst)
    begin
        if (i_rst)
        begin
            s1_reg <= '0;
            s2_reg <= '0;
            s3_reg <= '0;
            o_q    <= '0;
        end
        else
        begin
            s1_reg <= i_d;
            s2_reg <= s1_reg;
            s3_reg <= s2_reg;
            o_q    <= q_next;
        end
    end

endmodule
`default_nettype wire

// *** hdl/supply_supervisor_backup_switch.sv ***
// Summary of operation
// - Reset asserted once any supply reaches minimum
// - Reset held while main below reset threshold
// - Reset released fixed delay after upward crossing
// - Main drop reasserts reset, abandoning delay
// - Battery routed when forced or main too low
// - Battery indicator follows supply routing
// - Early warning follows low-line comparison only
// - Enabled chip-select path copies input
// - Path disabled, input high-impedance during reset once any drain ends
// - High input at power-down disables immediately
// - Low input disables on rise or timeout
// - Disabled path pulls output high
// - Battery measured periodically with short load
// - No battery measurement before reset release
// - Failed measurement drops battery-good flag
// - Monitor output follows monitor comparison
// - Seal keeps battery disconnected until released
// - Seal released on reset rising edge
// - Watchdog with fixed time-out period
// - Either kick edge restarts the watchdog
// - Backup mode persists until seal entry, or until switch off and main recovers
`default_nettype none
module supply_supervisor_backup_switch #(
    parameter int RESET_DELAY_CYC = supervisor_pkg::RESET_DELAY_CYC,
    parameter int WDOG_CYC        = supervisor_pkg::WDOG_CYC,
    parameter int BAT_PERIOD_CYC  = supervisor_pkg::BAT_PERIOD_CYC,
    parameter int BAT_ON_CYC      = supervisor_pkg::BAT_ON_CYC,
    parameter int SEAL_MIN_CYC    = supervisor_pkg::SEAL_MIN_CYC,
    parameter int SEAL_MAX_CYC    = supervisor_pkg::SEAL_MAX_CYC
) (
    // Clock and reset
    input  wire logic                  i_clk_sys,
    input  wire logic                  i_rst,
    // Comparator results and pins
    input  wire supervisor_pkg::pins_t i_pins,
    // Supply routing
    output var  logic                  o_switched_supply_sel,
    output var  logic                  o_on_battery_indicator,
    output var  logic                  o_battery_connect,
    // Reset and warnings
    output var  logic                  o_reset_n,
    output var  logic                  o_early_warning,
    // Monitor comparator pin
    output var  logic                  o_monitor_compare_output,
    output var  logic                  o_monitor_compare_oe,
    // Chip-select gating
    output var  logic                  o_chip_select_out,
    output var  logic                  o_chip_select_pullup_en,
    output var  logic                  o_chip_select_in_hiz,
    // Battery health
    output var  logic                  o_battery_load_en,
    output var  logic                  o_battery_good_flag
);

    localparam int CE_LAST = supervisor_pkg::CE_TIMEOUT_CYC;

    supervisor_pkg::pins_t      in;
    supervisor_pkg::rst_state_t state_reg;
    supervisor_pkg::rst_state_t state_next;
    supervisor_pkg::ce_state_t  ce_reg;
    supervisor_pkg::ce_state_t  ce_next;
    supervisor_pkg::cnt_t       dly_cnt_reg;
    supervisor_pkg::cnt_t       wd_cnt_reg;
    supervisor_pkg::cnt_t       bat_cnt_reg;
    supervisor_pkg::cnt_t       seal_cnt_reg;
    supervisor_pkg::cnt_t       ce_cnt_reg;
    logic                       kick_d_reg;
    logic                       above_reset_d_reg;
    logic                       bat_mode_reg;
    logic                       seal_reg;

    signal_sync3 #(
        .W (supervisor_pkg::PINS_W)
    ) u_sync (
        .i_clk_sys (i_clk_sys),
        .i_rst     (i_rst),
        .i_d       (i_pins),
        .o_q       (in)
    );

    // Reset sequencing
    wire main_ok     = in.above_min && in.above_reset;
    wire kick_edge   = in.kick != kick_d_reg;
    wire wdog_fire   = wd_cnt_reg == supervisor_pkg::cnt_t'(WDOG_CYC - 1);
    wire dly_done    = dly_cnt_reg == supervisor_pkg::cnt_t'(RESET_DELAY_CYC - 1);
    wire run_next    = state_next == supervisor_pkg::RST_RUN;
    wire rst_active  = !run_next;

    always_comb
    begin
        state_next = state_reg;
        case (state_reg)
            supervisor_pkg::RST_HOLD:
                if (main_ok)
                    state_next = supervisor_pkg::RST_DELAY;
            supervisor_pkg::RST_DELAY:
                if (!main_ok)
                    state_next = supervisor_pkg::RST_HOLD;
                else if (dly_done)
                    state_next = supervisor_pkg::RST_RUN;
            supervisor_pkg::RST_RUN:
                if (!main_ok)
                    state_next = supervisor_pkg::RST_HOLD;
                else if (wdog_fire)
                    state_next = supervisor_pkg::RST_DELAY;
            default:
                state_next = supervisor_pkg::RST_HOLD;
        endcase
    end

    // Supply routing; once in backup only seal entry or a recovering main with force released ends it
    wire bat_enter   = in.force_backup || (!in.above_reset && !in.above_bat);
    wire bat_exit    = !in.force_backup && (in.above_reset || in.above_bat);
    wire bat_mode_next = seal_reg ? 1'b0 : (bat_mode_reg ? !bat_exit : bat_enter);

    // Chip-select gate; a low input at reset may finish its write
    always_comb
    begin
        ce_next = ce_reg;
        case (ce_reg)
            supervisor_pkg::CE_ON:
                if (rst_active)
                    ce_next = in.cs_in ? supervisor_pkg::CE_OFF
                                       : supervisor_pkg::CE_DRAIN;
            supervisor_pkg::CE_DRAIN:
                if (!rst_active)
                    ce_next = supervisor_pkg::CE_ON;
                else if (in.cs_in || ce_cnt_reg == supervisor_pkg::cnt_t'(CE_LAST))
                    ce_next = supervisor_pkg::CE_OFF;
            supervisor_pkg::CE_OFF:
                if (!rst_active)
                    ce_next = supervisor_pkg::CE_ON;
            default:
                ce_next = supervisor_pkg::CE_OFF;
        endcase
    end

    wire ce_pass     = ce_next != supervisor_pkg::CE_OFF;

    // Battery measurement only while out of reset
    wire bat_wrap    = bat_cnt_reg == supervisor_pkg::cnt_t'(BAT_PERIOD_CYC - 1);
    wire bat_load    = run_next && bat_cnt_reg < supervisor_pkg::cnt_t'(BAT_ON_CYC);
    wire bat_sample  = state_reg == supervisor_pkg::RST_RUN
                       && bat_cnt_reg == supervisor_pkg::cnt_t'(BAT_ON_CYC - 1);

    // Seal entry: supply applied for a bounded time with the pin held low
    wire seal_cond   = in.above_reset && in.monitor_above_ref && !in.pfo_sense;
    wire seal_sat    = seal_cnt_reg == supervisor_pkg::cnt_t'(SEAL_MAX_CYC + 1);
    wire main_fell   = above_reset_d_reg && !in.above_reset;
    wire seal_window = seal_cnt_reg >= supervisor_pkg::cnt_t'(SEAL_MIN_CYC)
                       && seal_cnt_reg <= supervisor_pkg::cnt_t'(SEAL_MAX_CYC);
    wire reset_rise  = run_next && state_reg != supervisor_pkg::RST_RUN;

    always_ff @(posedge i_clk_sys or posedge i_rst)
    begin
        if (i_rst)
        begin
            state_reg   <= supervisor_pkg::RST_HOLD;
            dly_cnt_reg <= '0;
            wd_cnt_reg  <= '0;
            kick_d_reg  <= 1'b0;
            o_reset_n   <= 1'b0;
        end
        else
        begin
            state_reg   <= state_next;
            dly_cnt_reg <= (state_next == supervisor_pkg::RST_DELAY
                            && state_reg == supervisor_pkg::RST_DELAY)
                           ? dly_cnt_reg + 1'b1 : '0;
            wd_cnt_reg  <= (run_next && state_reg == supervisor_pkg::RST_RUN && !kick_edge)
                           ? wd_cnt_reg + 1'b1 : '0;
            kick_d_reg  <= in.kick;
            o_reset_n   <= run_next;
        end
    end

    always_ff @(posedge i_clk_sys or posedge i_rst)
    begin
        if (i_rst)
        begin
            bat_mode_reg           <= 1'b0;
            o_switched_supply_sel  <= 1'b0;
            o_on_battery_indicator <= 1'b0;
            o_battery_connect      <= 1'b0;
            o_early_warning        <= 1'b0;
            o_monitor_compare_output <= 1'b0;
            o_monitor_compare_oe   <= 1'b0;
        end
        else
        begin
            bat_mode_reg           <= bat_mode_next;
            o_switched_supply_sel  <= bat_mode_next;
            o_on_battery_indicator <= bat_mode_next;
            o_battery_connect      <= !seal_reg;
            o_early_warning        <= in.above_low_line;
            o_monitor_compare_output <= in.monitor_above_ref;
            o_monitor_compare_oe   <= 1'b1;
        end
    end

    always_ff @(posedge i_clk_sys or posedge i_rst)
    begin
        if (i_rst)
        begin
            ce_reg                  <= supervisor_pkg::CE_OFF;
            ce_cnt_reg              <= '0;
            o_chip_select_out       <= supervisor_pkg::CS_OUT_RST;
            o_chip_select_pullup_en <= 1'b1;
            o_chip_select_in_hiz    <= 1'b1;
        end
        else
        begin
            ce_reg                  <= ce_next;
            ce_cnt_reg              <= (ce_next == supervisor_pkg::CE_DRAIN)
                                       ? ce_cnt_reg + 1'b1 : '0;
            o_chip_select_out       <= ce_pass ? in.cs_in : 1'b1;
            o_chip_select_pullup_en <= !ce_pass;
            o_chip_select_in_hiz    <= !ce_pass;
        end
    end

    always_ff @(posedge i_clk_sys or posedge i_rst)
    begin
        if (i_rst)
        begin
            bat_cnt_reg         <= '0;
            o_battery_load_en   <= 1'b0;
            o_battery_good_flag <= supervisor_pkg::BAT_GOOD_RST;
        end
        else
        begin
            bat_cnt_reg         <= (!run_next || bat_wrap) ? '0 : bat_cnt_reg + 1'b1;
            o_battery_load_en   <= bat_load;
            if (bat_sample && !in.bat_above_good)
                o_battery_good_flag <= 1'b0;
        end
    end

    // Seal cannot end before it started, so the release edge wins over entry
    always_ff @(posedge i_clk_sys or posedge i_rst)
    begin
        if (i_rst)
        begin
            seal_cnt_reg      <= '0;
            above_reset_d_reg <= 1'b0;
            seal_reg          <= 1'b0;
        end
        else
        begin
            above_reset_d_reg <= in.above_reset;
            if (main_fell || !seal_cond)
                seal_cnt_reg <= '0;
            else if (!seal_sat)
                seal_cnt_reg <= seal_cnt_reg + 1'b1;
            if (reset_rise)
                seal_reg <= 1'b0;
            else if (main_fell && seal_window)
                seal_reg <= 1'b1;
        end
    end

    reset_low_a: assert property (
        @(posedge i_clk_sys) disable iff (i_rst)
        !in.above_reset |=> !o_reset_n)
        else $error("reset released with main below threshold");

    reset_abort_a: assert property (
        @(posedge i_clk_sys) disable iff (i_rst)
        state_reg == supervisor_pkg::RST_DELAY && !main_ok
        |=> state_reg == supervisor_pkg::RST_HOLD && dly_cnt_reg == '0)
        else $error("reset delay not abandoned");

    reset_delay_a: assert property (
        @(posedge i_clk_sys) disable iff (i_rst)
        $rose(o_reset_n) |-> $past(state_reg) == supervisor_pkg::RST_DELAY
            && $past(dly_cnt_reg) == supervisor_pkg::cnt_t'(RESET_DELAY_CYC - 1))
        else $error("reset released at wrong count");

    bat_route_a: assert property (
        @(posedge i_clk_sys) disable iff (i_rst)
        in.force_backup && !seal_reg |=> o_switched_supply_sel && o_on_battery_indicator)
        else $error("forced backup not routed");

    bat_indicator_a: assert property (
        @(posedge i_clk_sys) disable iff (i_rst)
        o_on_battery_indicator == o_switched_supply_sel)
        else $error("indicator disagrees with routing");

    early_warn_a: assert property (
        @(posedge i_clk_sys) disable iff (i_rst)
        ##1 o_early_warning == $past(in.above_low_line))
        else $error("early warning mismatch");

    ce_pass_a: assert property (
        @(posedge i_clk_sys) disable iff (i_rst)
        o_reset_n |-> o_chip_select_out == $past(in.cs_in) && !o_chip_select_in_hiz)
        else $error("chip select not passed");

    ce_pullup_a: assert property (
        @(posedge i_clk_sys) disable iff (i_rst)
        o_chip_select_pullup_en |-> o_chip_select_out && o_chip_select_in_hiz)
        else $error("disabled path not pulled high");

    ce_drain_a: assert property (
        @(posedge i_clk_sys) disable iff (i_rst)
        ce_reg == supervisor_pkg::CE_DRAIN |-> ce_cnt_reg <= supervisor_pkg::cnt_t'(CE_LAST + 1)
            && !$past(in.cs_in))
        else $error("drain held too long");

    bat_quiet_a: assert property (
        @(posedge i_clk_sys) disable iff (i_rst)
        !o_reset_n |-> !o_battery_load_en)
        else $error("battery load during reset");

    wdog_kick_a: assert property (
        @(posedge i_clk_sys) disable iff (i_rst)
        state_reg == supervisor_pkg::RST_RUN && kick_edge |=> wd_cnt_reg == '0)
        else $error("kick did not restart watchdog");

    monitor_out_a: assert property (
        @(posedge i_clk_sys) disable iff (i_rst)
        ##1 o_monitor_compare_output == $past(in.monitor_above_ref))
        else $error("monitor output mismatch");

endmodule
`default_nettype wire

// *** tb/host_ram_model.sv ***
`default_nettype none
module host_ram_model #(
    parameter int KICK_PERIOD = 120
) (
    // Clock and host state
    input  wire logic i_clk_sys,
    input  wire logic i_reset_n,
    // Scenario control
    input  wire logic i_kick_en,
    input  wire logic i_write_req,
    // Supervisor side
    output var  logic o_kick,
    output var  logic o_cs_in
);
    timeunit 1ns;
    timeprecision 100ps;

    int cnt;

    initial
    begin
        o_kick = 1'b0;
        o_cs_in = 1'b1;
        cnt = 0;
    end

    // One toggle per period: only a watchdog that counts both edges survives
    always @(posedge i_clk_sys)
    begin
        cnt <= (cnt >= KICK_PERIOD - 1) ? 0 : cnt + 1;
        if (i_kick_en && i_reset_n === 1'b1 && cnt == 0)
            o_kick <= #1 ~o_kick;
        o_cs_in <= #1 ~i_write_req;
    end
endmodule
`default_nettype wire

// *** tb/testbench.sv ***
`default_nettype none
module testbench;
    timeunit 1ns;
    timeprecision 100ps;

    localparam int RD = 20;
    localparam int WD = 200;
    localparam int BP = 100;
    localparam int BW = 5;
    localparam int KP = 120;
    localparam int CE = supervisor_pkg::CE_TIMEOUT_CYC;

    logic                  clk;
    logic                  rst;
    supervisor_pkg::pins_t drv;
    supervisor_pkg::pins_t pins_in;
    logic                  kick_en;
    logic                  write_req;
    logic                  pfo_gnd;
    logic                  kick;
    logic                  cs_in;
    logic                  sel;
    logic                  bat_ind;
    logic                  bconn;
    logic                  rst_n;
    logic                  early;
    logic                  mon_out;
    logic                  mon_oe;
    logic                  cs_out;
    logic                  pull;
    logic                  hiz;
    logic                  load_en;
    logic                  good;
    logic                  early_load;
    int                    n_errors;
    int                    total_checks;

    // Grounded pin wins over the driver; an undriven pin shows no stale level
    always_comb
    begin
        pins_in = drv;
        pins_in.kick = kick;
        pins_in.cs_in = cs_in;
        pins_in.pfo_sense = pfo_gnd ? 1'b0 : (mon_oe ? mon_out : ~mon_out);
    end

    always @(posedge clk)
        if (rst_n === 1'b0 && load_en === 1'b1)
            early_load <= 1'b1;

    supply_supervisor_backup_switch #(
        .RESET_DELAY_CYC (RD),
        .WDOG_CYC        (WD),
        .BAT_PERIOD_CYC  (BP),
        .BAT_ON_CYC      (BW),
        .SEAL_MIN_CYC    (10),
        .SEAL_MAX_CYC    (40)
    ) dut (
        .i_clk_sys                (clk),
        .i_rst                    (rst),
        .i_pins                   (pins_in),
        .o_switched_supply_sel    (sel),
        .o_on_battery_indicator   (bat_ind),
        .o_battery_connect        (bconn),
        .o_reset_n                (rst_n),
        .o_early_warning          (early),
        .o_monitor_compare_output (mon_out),
        .o_monitor_compare_oe     (mon_oe),
        .o_chip_select_out        (cs_out),
        .o_chip_select_pullup_en  (pull),
        .o_chip_select_in_hiz     (hiz),
        .o_battery_load_en        (load_en),
        .o_battery_good_flag      (good)
    );

    host_ram_model #(
        .KICK_PERIOD (KP)
    ) host (
        .i_clk_sys   (clk),
        .i_reset_n   (rst_n),
        .i_kick_en   (kick_en),
        .i_write_req (write_req),
        .o_kick      (kick),
        .o_cs_in     (cs_in)
    );

    task automatic check(input logic seen, input logic exp, input string what);
        total_checks++;
        if (seen !== exp)
        begin
            n_errors++;
            $display("FAIL %0t %s", $time, what);
        end
    endtask

    task automatic cyc(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask

    task automatic wait_rst(input logic lvl, input int lim, output int n);
        n = 0;
        while (rst_n !== lvl && n < lim)
        begin
            cyc(1);
            n++;
        end
    endtask

    task automatic drop;
        int n;
        drv.above_reset = 1'b0;
        wait_rst(1'b0, 10, n);
    endtask

    task automatic raise;
        int n;
        drv.above_reset = 1'b1;
        wait_rst(1'b1, RD + 20, n);
        check(n >= RD && n <= RD + 7, 1'b1, "release delay");
    endtask

    task automatic t_power;
        int n;
        cyc(10);
        check(rst_n, 1'b0, "reset before supply");
        drv = '{above_min: 1, above_bat: 1, above_low_line: 1, bat_above_good: 1,
                monitor_above_ref: 1, default: 0};
        cyc(40);
        check(rst_n, 1'b0, "reset below threshold");
        raise();
        check(early_load, 1'b0, "load before release");
        check(bconn, 1'b1, "battery connected");
        $display("test power finished");
    endtask

    task automatic t_drop;
        int n;
        drop();
        check(rst_n, 1'b0, "reset on drop");
        drv.above_reset = 1'b1;
        cyc(15);
        drop();
        cyc(10);
        raise();
        $display("test drop finished");
    endtask

    // Steps: force, above_reset, above_bat, low_line, monitor, expected routing
    task automatic t_route;
        logic [5:0] st [9];
        st = '{6'b011110, 6'b111001, 6'b011010, 6'b000111, 6'b100001,
               6'b000011, 6'b001110, 6'b101001, 6'b001110};
        foreach (st[i])
        begin
            {drv.force_backup, drv.above_reset, drv.above_bat} = st[i][5:3];
            {drv.above_low_line, drv.monitor_above_ref} = st[i][2:1];
            cyc(8);
            check(sel, st[i][0], "routing");
            check(bat_ind, st[i][0], "indicator");
            check(early, st[i][2], "early warning");
            check(mon_out, st[i][1], "monitor output");
            check(mon_oe, 1'b1, "monitor pin driven");
        end
        raise();
        $display("test route finished");
    endtask

    task automatic t_cs;
        write_req = 1'b1;
        cyc(8);
        check(cs_out, 1'b0, "cs low copied");
        check(pull, 1'b0, "pullup off");
        check(hiz, 1'b0, "input driven");
        write_req = 1'b0;
        cyc(8);
        check(cs_out, 1'b1, "cs high copied");
        drop();
        check(hiz, 1'b1, "immediate disable");
        check(pull, 1'b1, "pullup on");
        write_req = 1'b1;
        cyc(8);
        check(cs_out, 1'b1, "blocked in reset");
        raise();
        cyc(4);
        drop();
        cyc(20);
        check(hiz, 1'b0, "write allowed");
        check(cs_out, 1'b0, "write passes");
        write_req = 1'b0;
        cyc(8);
        check(hiz, 1'b1, "disabled on rise");
        check(cs_out, 1'b1, "held high");
        raise();
        write_req = 1'b1;
        cyc(8);
        drop();
        cyc(CE - 20);
        check(hiz, 1'b0, "before timeout");
        cyc(30);
        check(hiz, 1'b1, "after timeout");
        check(pull, 1'b1, "pullup after timeout");
        write_req = 1'b0;
        raise();
        $display("test cs finished");
    endtask

    task automatic t_bat;
        int n;
        int w;
        n = 0;
        while (load_en !== 1'b1 && n < 2 * BP)
        begin
            cyc(1);
            n++;
        end
        w = 0;
        while (load_en === 1'b1 && w < BP)
        begin
            cyc(1);
            w++;
        end
        check(w == BW, 1'b1, "load on-time");
        while (load_en !== 1'b1 && w < 2 * BP)
        begin
            cyc(1);
            w++;
        end
        check(w == BP, 1'b1, "load period");
        check(good, 1'b1, "flag high when good");
        drv.bat_above_good = 1'b0;
        cyc(BP + 10);
        check(good, 1'b0, "flag drops");
        drv.bat_above_good = 1'b1;
        cyc(2 * BP);
        check(good, 1'b0, "flag sticky");
        $display("test battery finished");
    endtask

    task automatic t_wdog;
        int n;
        cyc(3 * WD);
        check(rst_n, 1'b1, "kicked watchdog quiet");
        kick_en = 1'b0;
        wait_rst(1'b0, WD + 60, n);
        check(n >= WD - KP - 8 && n <= WD + 8, 1'b1, "time-out");
        wait_rst(1'b1, RD + 20, n);
        check(n >= RD && n <= RD + 3, 1'b1, "time-out pulse");
        kick_en = 1'b1;
        $display("test watchdog finished");
    endtask

    task automatic t_seal;
        drv.above_bat = 1'b0;
        drop();
        cyc(8);
        pfo_gnd = 1'b1;
        drv.above_reset = 1'b1;
        cyc(15);
        drv.above_reset = 1'b0;
        cyc(8);
        check(bconn, 1'b0, "sealed");
        check(sel, 1'b0, "sealed keeps main");
        pfo_gnd = 1'b0;
        drv.above_bat = 1'b1;
        cyc(RD - 5);
        check(bconn, 1'b0, "seal until release");
        raise();
        cyc(2);
        check(bconn, 1'b1, "seal released");
        $display("test seal finished");
    endtask

    task automatic finish_test;
        $display("checks %0d errors %0d", total_checks, n_errors);
        if (n_errors == 0 && total_checks > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask

    initial
    begin
        clk = 1'b0;
        forever #2 clk = ~clk;
    end

    // Longest scenario is the drain time-out; the rest are a few hundred cycles
    initial
    begin
        #200000;
        n_errors++;
        $display("FAIL %0t watchdog expired", $time);
        finish_test();
    end

    initial
    begin
        rst = 1'b1;
        drv = '0;
        kick_en = 1'b1;
        write_req = 1'b0;
        pfo_gnd = 1'b0;
        early_load = 1'b0;
        n_errors = 0;
        total_checks = 0;
        repeat (5) @(posedge clk);
        #1;
        rst = 1'b0;
        t_power();
        t_drop();
        t_route();
        t_cs();
        t_bat();
        t_wdog();
        t_seal();
        finish_test();
    end
endmodule
`default_nettype wire
